// >>> dtiu_pkg.sv
// Package for the dual timer and interrupt unit: port numbers, field layout,
// reset values, source indices and vectors.
// Assumes a single clock domain shared with the processor core.
package dtiu_pkg;
	// Command port numbers seen on the core's output-port bus.
	localparam logic [4:0] DTIU_PORT_TIMER_A_CMD = 5'h1c;
	localparam logic [4:0] DTIU_PORT_TIMER_B_CMD = 5'h1d;
	// Command field layout.
	localparam int DTIU_MODE_HI = 3;
	localparam int DTIU_MODE_LO = 2;
	localparam int DTIU_RATE_HI = 1;
	localparam int DTIU_RATE_LO = 0;
	localparam logic [1:0] DTIU_MODE_STOP = 2'h0;
	localparam logic [1:0] DTIU_MODE_TIMER = 2'h2;
	localparam logic [3:0] DTIU_CMD_RESET = 4'h0;
	// Prescaler tap positions for rate codes 00..11 (divide by 2^5,2^7,2^11,2^15).
	localparam int DTIU_TAP0 = 4;
	localparam int DTIU_TAP1 = 6;
	localparam int DTIU_TAP2 = 10;
	localparam int DTIU_TAP3 = 14;
	localparam int DTIU_PRESCALE_W = 15;
	// Count width and nibble select codes.
	localparam int DTIU_COUNT_W = 12;
	localparam logic [1:0] DTIU_NIB_LOW = 2'h0;
	localparam logic [1:0] DTIU_NIB_MID = 2'h1;
	localparam logic [1:0] DTIU_NIB_HIGH = 2'h2;
	// Latch bit positions of each source.
	localparam int DTIU_SRC_N = 6;
	localparam int DTIU_IL_EXT0 = 5;
	localparam int DTIU_IL_RSVD = 4;
	localparam int DTIU_IL_TMRA = 3;
	localparam int DTIU_IL_TMRB = 2;
	localparam int DTIU_IL_TICK = 1;
	localparam int DTIU_IL_EXT1 = 0;
	// Mask bit positions.
	localparam int DTIU_MASK_RSVD = 3;
	localparam int DTIU_MASK_TMRA = 2;
	localparam int DTIU_MASK_TMRB = 1;
	localparam int DTIU_MASK_EXT1 = 0;
	localparam logic [3:0] DTIU_MASK_RESET = 4'h0;
	localparam logic [5:0] DTIU_IL_RESET = 6'h00;
	// Vectors, indexed by latch bit position.
	localparam logic [11:0] DTIU_VEC_EXT0 = 12'h002;
	localparam logic [11:0] DTIU_VEC_RSVD = 12'h004;
	localparam logic [11:0] DTIU_VEC_TMRA = 12'h006;
	localparam logic [11:0] DTIU_VEC_TMRB = 12'h008;
	localparam logic [11:0] DTIU_VEC_TICK = 12'h00a;
	localparam logic [11:0] DTIU_VEC_EXT1 = 12'h00c;
	localparam logic [11:0] DTIU_VEC_NONE = 12'h000;
	localparam logic DTIU_SF_RESET = 1'b1;
endpackage : dtiu_pkg

// >>> dtiu_timer.sv
// One 12-bit up-counting timer with its own command port.
// Assumes the shared prescaler tap strobes are one-cycle pulses on the clock.
`timescale 1ns/1ps
module dtiu_timer
	import dtiu_pkg::*;
#(
	parameter int COUNT_W = DTIU_COUNT_W
) (
	input wire logic i_mclk,
	input wire logic i_resetn,
	input wire logic [3:0] i_rate_ticks, // One-cycle rising-edge strobes per rate code.
	input wire logic i_cmd_we, // Command port write strobe.
	input wire logic [3:0] i_cmd_data, // Command port data.
	input wire logic i_load_we, // Nibble preload strobe.
	input wire logic [1:0] i_nib_sel, // Nibble selected for load and read.
	input wire logic [3:0] i_load_data, // Nibble preload value.
	output logic [3:0] o_read_nibble, // Selected nibble of the count, registered.
	output logic o_overflow // One-cycle overflow request, registered.
);
	// ==========================================================
	// Command register
	logic [3:0] cmd_r; // Mode in bits 3:2, rate in bits 1:0.
	logic [COUNT_W-1:0] count_r; // Running count.
	logic tick; // Selected counting pulse.
	logic running; // Timer mode is selected.

	// The command port clears to stop mode with the fastest rate on reset.
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			cmd_r <= DTIU_CMD_RESET;
		end else if (i_cmd_we) begin
			cmd_r <= i_cmd_data;
		end
	end

	// Reserved modes count as stop so the counter never runs unintended.
	assign running = (cmd_r[DTIU_MODE_HI:DTIU_MODE_LO] == DTIU_MODE_TIMER);
	assign tick = i_rate_ticks[cmd_r[DTIU_RATE_HI:DTIU_RATE_LO]];

	// ==========================================================
	// Counter
	// A preload wins over a tick in the same cycle, the core's write is kept.
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			count_r <= '0;
		end else if (i_load_we) begin
			case (i_nib_sel)
				DTIU_NIB_LOW: count_r[3:0] <= i_load_data;
				DTIU_NIB_MID: count_r[7:4] <= i_load_data;
				DTIU_NIB_HIGH: count_r[11:8] <= i_load_data;
				default: count_r <= count_r;
			endcase
		end else if (running && tick) begin
			count_r <= count_r + 1'b1;
		end
	end

	// Overflow request pulses on the wrap from all ones to zero.
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_overflow <= 1'b0;
		end else begin
			o_overflow <= !i_load_we && running && tick && (&count_r);
		end
	end

	// Readback nibble, registered so it appears one cycle after the select.
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_read_nibble <= 4'h0;
		end else begin
			case (i_nib_sel)
				DTIU_NIB_LOW: o_read_nibble <= count_r[3:0];
				DTIU_NIB_MID: o_read_nibble <= count_r[7:4];
				DTIU_NIB_HIGH: o_read_nibble <= count_r[11:8];
				default: o_read_nibble <= 4'h0;
			endcase
		end
	end
endmodule : dtiu_timer

// >>> dtiu_top.sv
// Dual timer and prioritised interrupt controller of a 4-bit controller.
// Assumes the core presents port writes, timer nibble accesses, mask and latch
// writes and the return strobe as one-cycle pulses on the oscillator clock.
`timescale 1ns/1ps
module dtiu_top
	import dtiu_pkg::*;
#(
	parameter int COUNT_W = DTIU_COUNT_W,
	parameter int PRESCALE_W = DTIU_PRESCALE_W
) (
	input wire logic i_mclk, // Oscillator clock.
	input wire logic i_resetn, // Asynchronous active-low system reset.
	input wire logic i_port_we, // Output-port write strobe.
	input wire logic [4:0] i_port_addr, // Output-port number.
	input wire logic [3:0] i_port_data, // Output-port data.
	input wire logic i_tmr_we, // Timer nibble write strobe.
	input wire logic i_tmr_sel_b, // Selects timer B for nibble writes.
	input wire logic [1:0] i_tmr_nib, // Nibble select low, mid, high.
	input wire logic [3:0] i_tmr_wdata, // Nibble write value.
	input wire logic i_external_request_zero, // External request zero, one-cycle pulse.
	input wire logic i_external_request_one, // External request one, one-cycle pulse.
	input wire logic i_periodic_tick_request, // Time-base request, one-cycle pulse.
	input wire logic i_mask_we, // Mask register write strobe.
	input wire logic [3:0] i_mask_wdata, // New mask value.
	input wire logic i_latch_clr_we, // Latch write strobe, zeros clear.
	input wire logic [5:0] i_latch_keep, // Bits at zero clear their latch.
	input wire logic i_enable_we, // Global enable write strobe.
	input wire logic i_enable_wdata, // New global enable value.
	input wire logic i_flag_we, // Status flag update from the ALU.
	input wire logic i_flag_wdata, // New status flag value.
	input wire logic i_irq_ack, // Core accepts the request and takes the vector.
	input wire logic i_return_from_irq, // Return instruction executed.
	output logic [3:0] o_count_a_nibble, // Timer A selected nibble.
	output logic [3:0] o_count_b_nibble, // Timer B selected nibble.
	output logic o_irq_req, // A gated request is pending.
	output logic [11:0] o_irq_vector, // Vector of the winning source.
	output logic o_push_context, // One-cycle push of PC and flags.
	output logic o_pop_context, // One-cycle restore of PC and flags.
	output logic o_branch_condition_flag, // Status flag used by branches.
	output logic o_global_irq_enable, // Global enable state.
	output logic [3:0] o_source_gate, // Mask register state.
	output logic [5:0] o_request_latch // Latch state.
);
	// ==========================================================
	// Shared prescaler and rate strobes
	logic [PRESCALE_W-1:0] presc_r; // Free-running oscillator divider.
	logic [PRESCALE_W-1:0] presc_nxt; // Next divider value.
	logic [3:0] rate_ticks; // Rising edges of each tap.
	logic tmr_a_we; // Nibble preload for timer A.
	logic tmr_b_we; // Nibble preload for timer B.
	logic ovf_a; // Overflow request of timer A.
	logic ovf_b; // Overflow request of timer B.

	assign presc_nxt = presc_r + 1'b1;

	// A tap rises when it is low now and high on the next count.
	function automatic logic tap_rise(input logic [PRESCALE_W-1:0] cur,
			input logic [PRESCALE_W-1:0] nxt, input int tap);
		tap_rise = !cur[tap] && nxt[tap];
	endfunction : tap_rise

	assign rate_ticks[0] = tap_rise(presc_r, presc_nxt, DTIU_TAP0);
	assign rate_ticks[1] = tap_rise(presc_r, presc_nxt, DTIU_TAP1);
	assign rate_ticks[2] = tap_rise(presc_r, presc_nxt, DTIU_TAP2);
	assign rate_ticks[3] = tap_rise(presc_r, presc_nxt, DTIU_TAP3);

	// Divider runs from reset onward.
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			presc_r <= '0;
		end else begin
			presc_r <= presc_nxt;
		end
	end

	// Decode of a command port write for a given port number.
	function automatic logic port_hit(input logic we, input logic [4:0] addr,
			input logic [4:0] port);
		port_hit = we && (addr == port);
	endfunction : port_hit

	assign tmr_a_we = i_tmr_we && !i_tmr_sel_b;
	assign tmr_b_we = i_tmr_we && i_tmr_sel_b;

	// ==========================================================
	// The two timers, identical and independent
	dtiu_timer #(.COUNT_W(COUNT_W)) u_timer_a (
		.i_mclk(i_mclk),
		.i_resetn(i_resetn),
		.i_rate_ticks(rate_ticks),
		.i_cmd_we(port_hit(i_port_we, i_port_addr, DTIU_PORT_TIMER_A_CMD)),
		.i_cmd_data(i_port_data),
		.i_load_we(tmr_a_we),
		.i_nib_sel(i_tmr_nib),
		.i_load_data(i_tmr_wdata),
		.o_read_nibble(o_count_a_nibble),
		.o_overflow(ovf_a)
	);

	dtiu_timer #(.COUNT_W(COUNT_W)) u_timer_b (
		.i_mclk(i_mclk),
		.i_resetn(i_resetn),
		.i_rate_ticks(rate_ticks),
		.i_cmd_we(port_hit(i_port_we, i_port_addr, DTIU_PORT_TIMER_B_CMD)),
		.i_cmd_data(i_port_data),
		.i_load_we(tmr_b_we),
		.i_nib_sel(i_tmr_nib),
		.i_load_data(i_tmr_wdata),
		.o_read_nibble(o_count_b_nibble),
		.o_overflow(ovf_b)
	);

	// ==========================================================
	// Request latches
	logic [5:0] req_in; // Raw requests by latch position.
	logic [5:0] gated; // Latched requests that pass the gating.
	logic [5:0] grant; // One-hot winner.
	logic [5:0] grant_r; // Winner behind the vector the core now sees.
	logic [5:0] take; // Latch cleared by acceptance this cycle.
	logic [11:0] vec_nxt; // Vector of the winner.

	assign req_in[DTIU_IL_EXT0] = i_external_request_zero;
	assign req_in[DTIU_IL_RSVD] = 1'b0; // Reserved source never requests.
	assign req_in[DTIU_IL_TMRA] = ovf_a;
	assign req_in[DTIU_IL_TMRB] = ovf_b;
	assign req_in[DTIU_IL_TICK] = i_periodic_tick_request;
	assign req_in[DTIU_IL_EXT1] = i_external_request_one;

	// Acceptance clears the source whose vector was shown, not a later newcomer.
	assign take = (i_irq_ack && o_irq_req) ? grant_r : 6'h00;

	// A new request beats both software clear and acceptance clear.
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_request_latch <= DTIU_IL_RESET;
		end else begin
			o_request_latch <= ((o_request_latch & ~take)
				& (i_latch_clr_we ? i_latch_keep : 6'h3f))
				| req_in;
		end
	end

	// ==========================================================
	// Gating and priority
	// The time base source has no mask; only the global enable gates it.
	always_comb begin
		gated = 6'h00;
		if (o_global_irq_enable) begin
			gated[DTIU_IL_EXT0] = o_request_latch[DTIU_IL_EXT0];
			gated[DTIU_IL_RSVD] = o_request_latch[DTIU_IL_RSVD] && o_source_gate[DTIU_MASK_RSVD];
			gated[DTIU_IL_TMRA] = o_request_latch[DTIU_IL_TMRA] && o_source_gate[DTIU_MASK_TMRA];
			gated[DTIU_IL_TMRB] = o_request_latch[DTIU_IL_TMRB] && o_source_gate[DTIU_MASK_TMRB];
			gated[DTIU_IL_TICK] = o_request_latch[DTIU_IL_TICK];
			gated[DTIU_IL_EXT1] = o_request_latch[DTIU_IL_EXT1] && o_source_gate[DTIU_MASK_EXT1];
		end
	end

	// Highest latch position has highest priority.
	always_comb begin
		grant = 6'h00;
		vec_nxt = DTIU_VEC_NONE;
		if (gated[DTIU_IL_EXT0]) begin
			grant[DTIU_IL_EXT0] = 1'b1;
			vec_nxt = DTIU_VEC_EXT0;
		end else if (gated[DTIU_IL_RSVD]) begin
			grant[DTIU_IL_RSVD] = 1'b1;
			vec_nxt = DTIU_VEC_RSVD;
		end else if (gated[DTIU_IL_TMRA]) begin
			grant[DTIU_IL_TMRA] = 1'b1;
			vec_nxt = DTIU_VEC_TMRA;
		end else if (gated[DTIU_IL_TMRB]) begin
			grant[DTIU_IL_TMRB] = 1'b1;
			vec_nxt = DTIU_VEC_TMRB;
		end else if (gated[DTIU_IL_TICK]) begin
			grant[DTIU_IL_TICK] = 1'b1;
			vec_nxt = DTIU_VEC_TICK;
		end else if (gated[DTIU_IL_EXT1]) begin
			grant[DTIU_IL_EXT1] = 1'b1;
			vec_nxt = DTIU_VEC_EXT1;
		end
	end

	// Registered request and vector; both follow the latches one cycle later.
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_irq_req <= 1'b0;
			o_irq_vector <= DTIU_VEC_NONE;
			grant_r <= 6'h00;
		end else begin
			o_irq_req <= (|gated) && !(i_irq_ack && o_irq_req);
			o_irq_vector <= vec_nxt;
			grant_r <= grant;
		end
	end

	// ==========================================================
	// Enable, masks, status flag and context strobes
	// Acceptance clears the enable above any software write or return.
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_global_irq_enable <= 1'b0;
		end else if (i_irq_ack && o_irq_req) begin
			o_global_irq_enable <= 1'b0;
		end else if (i_return_from_irq) begin
			o_global_irq_enable <= 1'b1;
		end else if (i_enable_we) begin
			o_global_irq_enable <= i_enable_wdata;
		end
	end

	// Mask register, written by software only.
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_source_gate <= DTIU_MASK_RESET;
		end else if (i_mask_we) begin
			o_source_gate <= i_mask_wdata;
		end
	end

	// Status flag: set on acceptance, otherwise follows the ALU.
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_branch_condition_flag <= DTIU_SF_RESET;
		end else if (i_irq_ack && o_irq_req) begin
			o_branch_condition_flag <= 1'b1;
		end else if (i_flag_we) begin
			o_branch_condition_flag <= i_flag_wdata;
		end
	end

	// Push on acceptance, pop on return; the core moves PC and flags.
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_push_context <= 1'b0;
			o_pop_context <= 1'b0;
		end else begin
			o_push_context <= i_irq_ack && o_irq_req;
			o_pop_context <= i_return_from_irq;
		end
	end
endmodule : dtiu_top

// >>> dtiu_top_asserts.sv
// Checker for the dual timer and interrupt unit, watching its top ports only.
// Assumes one oscillator clock and the asynchronous active-low reset.
`timescale 1ns/1ps
module dtiu_top_asserts
	import dtiu_pkg::*;
#(
	parameter int COUNT_W = DTIU_COUNT_W,
	parameter int PRESCALE_W = DTIU_PRESCALE_W
) (
	input wire logic i_mclk,
	input wire logic i_resetn,
	input wire logic i_external_request_zero,
	input wire logic i_external_request_one,
	input wire logic i_periodic_tick_request,
	input wire logic i_mask_we,
	input wire logic [3:0] i_mask_wdata,
	input wire logic i_latch_clr_we,
	input wire logic [5:0] i_latch_keep,
	input wire logic i_enable_we,
	input wire logic i_irq_ack,
	input wire logic i_return_from_irq,
	input wire logic o_irq_req,
	input wire logic [11:0] o_irq_vector,
	input wire logic o_push_context,
	input wire logic o_pop_context,
	input wire logic o_branch_condition_flag,
	input wire logic o_global_irq_enable,
	input wire logic [3:0] o_source_gate,
	input wire logic [5:0] o_request_latch
);
	// ====================
	// All checks share the oscillator clock and sleep during reset.
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_resetn);
	chk_accept_pushes: assert property (i_irq_ack && o_irq_req |=> o_push_context &&
		!o_global_irq_enable && o_branch_condition_flag && !o_irq_req)
		else $error("acceptance did not push and disable");
	chk_return_pops: assert property (i_return_from_irq && !i_enable_we &&
		!(i_irq_ack && o_irq_req) |=> o_pop_context && o_global_irq_enable)
		else $error("return did not pop and enable");
	chk_push_cause: assert property (o_push_context |-> $past(i_irq_ack) && $past(o_irq_req))
		else $error("push without acceptance");
	chk_req_gated: assert property (!o_global_irq_enable && !$past(o_global_irq_enable)
		|-> !o_irq_req)
		else $error("request while globally disabled");
	chk_ext0_latches: assert property (i_external_request_zero && !i_irq_ack
		|=> o_request_latch[DTIU_IL_EXT0])
		else $error("external request zero not latched");
	chk_latch_no_set: assert property ($rose(o_request_latch[DTIU_IL_EXT1])
		|-> $past(i_external_request_one))
		else $error("latch set without its source");
	chk_vec_priority: assert property (o_irq_req && $stable(o_request_latch) &&
		o_request_latch[DTIU_IL_EXT0] |-> o_irq_vector == DTIU_VEC_EXT0)
		else $error("highest source not vectored");
	chk_mask_write: assert property (i_mask_we |=> o_source_gate == $past(i_mask_wdata))
		else $error("mask write lost");
	chk_latch_clear: assert property (i_latch_clr_we && !i_irq_ack && !i_external_request_zero &&
		!i_external_request_one && !i_periodic_tick_request
		|=> (o_request_latch & ~$past(i_latch_keep) & 6'h33) == 6'h00)
		else $error("latch clear ignored");
endmodule : dtiu_top_asserts

bind dtiu_top dtiu_top_asserts #(.COUNT_W(COUNT_W), .PRESCALE_W(PRESCALE_W)) u_chk (
	.i_mclk, .i_resetn, .i_external_request_zero, .i_external_request_one,
	.i_periodic_tick_request, .i_mask_we, .i_mask_wdata, .i_latch_clr_we, .i_latch_keep,
	.i_enable_we, .i_irq_ack, .i_return_from_irq, .o_irq_req, .o_irq_vector, .o_push_context,
	.o_pop_context, .o_branch_condition_flag, .o_global_irq_enable, .o_source_gate,
	.o_request_latch
);

// >>> dtiu_core_model.sv
// Processor core model that accepts vectored requests and returns from service.
// Assumes the unit's registered outputs; drives its strobes at falling edges.
`timescale 1ns/1ps
module dtiu_core_model (
	input wire logic i_mclk,
	input wire logic i_resetn,
	input wire logic i_auto, // Serve requests while high.
	input wire logic [3:0] i_wait, // Cycles before acknowledge and before return.
	input wire logic i_irq_req,
	input wire logic [11:0] i_irq_vector,
	output logic o_irq_ack,
	output logic o_return_from_irq,
	output logic [11:0] o_taken_vec, // Vector seen at the last acknowledge.
	output int o_taken_cnt // Number of acknowledges so far.
);
	// ====================
	// Acknowledge a standing request, then return after the same wait.
	initial begin
		o_irq_ack = 1'b0;
		o_return_from_irq = 1'b0;
		o_taken_vec = 12'h000;
		o_taken_cnt = 0;
		forever begin
			@(negedge i_mclk);
			if (i_auto && i_resetn && i_irq_req) begin
				repeat (i_wait) @(negedge i_mclk);
				o_taken_vec = i_irq_vector;
				o_irq_ack = 1'b1;
				@(negedge i_mclk);
				o_irq_ack = 1'b0;
				o_taken_cnt++;
				repeat (i_wait) @(negedge i_mclk);
				o_return_from_irq = 1'b1;
				@(negedge i_mclk);
				o_return_from_irq = 1'b0;
			end
		end
	end
endmodule : dtiu_core_model

// >>> dtiu_top_tb.sv
// Self-checking bench for dtiu_top with a core model serving its requests.
// Assumes the package, the core model and the checker are compiled first.
`timescale 1ns/1ps
module dtiu_top_tb;
	typedef struct packed {logic [3:0] mask; logic [2:0] src; logic [5:0] latch;
		logic [11:0] vec;} dtiu_row_t;
	logic i_mclk, i_resetn, i_port_we, i_tmr_we, i_tmr_sel_b, i_mask_we, i_latch_clr_we;
	logic i_enable_we, i_enable_wdata, i_flag_we, i_flag_wdata, i_auto, i_irq_ack;
	logic i_external_request_zero, i_external_request_one, i_periodic_tick_request;
	logic i_return_from_irq, o_irq_req, o_push_context, o_pop_context;
	logic o_branch_condition_flag, o_global_irq_enable;
	logic [4:0] i_port_addr;
	logic [3:0] i_port_data, i_tmr_wdata, i_mask_wdata, i_wait, o_source_gate;
	logic [3:0] o_count_a_nibble, o_count_b_nibble;
	logic [1:0] i_tmr_nib;
	logic [5:0] i_latch_keep, o_request_latch;
	logic [11:0] o_irq_vector, taken_vec;
	int taken_cnt, error_cnt, checked, n_exp;
	// Ordinary cases: mask, request (zero, one, tick), latch after, vector taken.
	dtiu_row_t rows [5] = '{'{4'h0, 3'b100, 6'h00, 12'h002}, '{4'h0, 3'b010, 6'h01, 12'h000},
		'{4'h1, 3'b010, 6'h00, 12'h00c}, '{4'he, 3'b001, 6'h00, 12'h00a},
		'{4'he, 3'b010, 6'h01, 12'h000}};
	logic [11:0] pv [3] = '{12'h002, 12'h00a, 12'h00c};
	logic [8:0] stp [4] = '{9'h1c0, 9'h1c4, 9'h1cc, 9'h1b8};
	int per [4] = '{128, 512, 8192, 32768};
	dtiu_top uut (.i_mclk, .i_resetn, .i_port_we, .i_port_addr, .i_port_data, .i_tmr_we,
		.i_tmr_sel_b, .i_tmr_nib, .i_tmr_wdata, .i_external_request_zero, .i_external_request_one,
		.i_periodic_tick_request, .i_mask_we, .i_mask_wdata, .i_latch_clr_we, .i_latch_keep,
		.i_enable_we, .i_enable_wdata, .i_flag_we, .i_flag_wdata, .i_irq_ack, .i_return_from_irq,
		.o_count_a_nibble, .o_count_b_nibble, .o_irq_req, .o_irq_vector, .o_push_context,
		.o_pop_context, .o_branch_condition_flag, .o_global_irq_enable, .o_source_gate,
		.o_request_latch);
	dtiu_core_model u_core (.i_mclk, .i_resetn, .i_auto, .i_wait, .i_irq_req(o_irq_req),
		.i_irq_vector(o_irq_vector), .o_irq_ack(i_irq_ack), .o_return_from_irq(i_return_from_irq),
		.o_taken_vec(taken_vec), .o_taken_cnt(taken_cnt));
	// ====================
	// Clock at 100 MHz.
	initial begin
		i_mclk = 1'b0;
		forever #5 i_mclk = ~i_mclk;
	end
	task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	task automatic tick(input int n);
		repeat (n) @(negedge i_mclk);
	endtask : tick
	task automatic port(input logic [4:0] a, input logic [3:0] d);
		{i_port_we, i_port_addr, i_port_data} = {1'b1, a, d};
		tick(1);
		i_port_we = 1'b0;
	endtask : port
	task automatic load(input logic b, input logic [1:0] n, input logic [3:0] d);
		{i_tmr_we, i_tmr_sel_b, i_tmr_nib, i_tmr_wdata} = {1'b1, b, n, d};
		tick(1);
		i_tmr_we = 1'b0;
		tick(1);
	endtask : load
	// Selects a nibble; the registered copy is read one cycle later.
	task automatic rd(input logic b, input logic [1:0] n, output logic [3:0] v);
		{i_tmr_sel_b, i_tmr_nib} = {b, n};
		tick(1);
		v = b ? o_count_b_nibble : o_count_a_nibble;
	endtask : rd
	// Writes mask, enable and latch keep bits together; the ALU clears the flag.
	task automatic setup(input logic [3:0] m, input logic e, input logic [5:0] k);
		{i_mask_we, i_enable_we, i_latch_clr_we, i_flag_we} = 4'hf;
		{i_mask_wdata, i_enable_wdata, i_latch_keep, i_flag_wdata} = {m, e, k, 1'b0};
		tick(1);
		{i_mask_we, i_enable_we, i_latch_clr_we, i_flag_we} = 4'h0;
	endtask : setup
	task automatic req(input logic [2:0] s);
		{i_external_request_zero, i_external_request_one, i_periodic_tick_request} = s;
		tick(1);
		{i_external_request_zero, i_external_request_one, i_periodic_tick_request} = 3'b000;
	endtask : req
	// Waits, bounded, for the core model to take one more request.
	task automatic take(input logic [11:0] vec);
		n_exp++;
		for (int i = 0; i < 5000 && taken_cnt < n_exp; i++) tick(1);
		cmp(12'(taken_cnt), 12'(n_exp));
		cmp(taken_vec, vec);
	endtask : take
	// Holds reset for three cycles, releases it off the edge and checks the reset state.
	task automatic reset_check();
		i_resetn = 1'b0;
		tick(3);
		i_resetn = 1'b1;
		tick(1);
		cmp({o_global_irq_enable, o_source_gate, o_request_latch}, 12'h000);
		cmp({o_branch_condition_flag, o_irq_req, o_push_context, o_pop_context}, 4'h8);
	endtask : reset_check
	task automatic finish_test();
		$display("error_cnt=%0d checked=%0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : finish_test
	// ====================
	// Watchdog, well beyond the longest expected run.
	initial begin
		repeat (60000) @(posedge i_mclk);
		error_cnt++;
		finish_test();
	end
	initial begin
		logic [3:0] v, v0;
		{i_port_we, i_port_addr, i_port_data, i_tmr_we, i_tmr_sel_b, i_tmr_wdata} = '0;
		{i_mask_we, i_mask_wdata, i_latch_clr_we, i_latch_keep, i_enable_we, i_enable_wdata} = '0;
		{i_flag_we, i_flag_wdata, i_auto, i_wait} = '0;
		{i_external_request_zero, i_external_request_one, i_periodic_tick_request} = '0;
		i_tmr_nib = 2'h3;
		reset_check();
		for (int t = 0; t < 2; t++) begin
			rd(t[0], 2'h0, v0);
			tick(70);
			rd(t[0], 2'h0, v);
			cmp(v, v0);
		end
		// Table of single sources under various masks, served fast and slow.
		i_auto = 1'b1;
		foreach (rows[i]) begin
			i_wait = (i % 2) ? 4'h3 : 4'h0;
			setup(rows[i].mask, 1'b1, 6'h00);
			req(rows[i].src);
			tick(14);
			if (rows[i].vec !== 12'h000) take(rows[i].vec);
			cmp(12'(taken_cnt), 12'(n_exp));
			cmp(o_request_latch, rows[i].latch);
			cmp(o_global_irq_enable, 1'b1);
			cmp(o_branch_condition_flag, rows[i].vec != 12'h000);
		end
		// Three sources at once, held off by the global enable, then served in order.
		i_auto = 1'b0;
		setup(4'h1, 1'b0, 6'h00);
		req(3'b111);
		tick(3);
		cmp({o_irq_req, o_request_latch}, 7'h23);
		i_auto = 1'b1;
		setup(4'h1, 1'b1, 6'h3f);
		for (int k = 0; k < 3; k++) take(pv[k]);
		tick(4);
		// Software clears one latch while a new request wins over its own clear.
		setup(4'h0, 1'b0, 6'h00);
		{i_external_request_zero, i_external_request_one} = 2'b11;
		tick(1);
		i_external_request_one = 1'b0;
		setup(4'h0, 1'b0, 6'h1e);
		i_external_request_zero = 1'b0;
		tick(1);
		cmp(o_request_latch, 6'h20);
		// Each timer preloaded near the top, run, and its overflow served.
		for (int t = 0; t < 2; t++) begin
			setup(t ? 4'h2 : 4'h4, 1'b1, 6'h00);
			load(t[0], 2'h0, 4'he);
			load(t[0], 2'h1, 4'hf);
			load(t[0], 2'h2, 4'hf);
			rd(t[0], 2'h0, v);
			cmp(v, 4'he);
			rd(t[0], 2'h2, v);
			cmp(v, 4'hf);
			port(5'(5'h1c + t), 4'h8);
			take(12'(12'h006 + 2 * t));
			rd(t[0], 2'h2, v);
			cmp(v, 4'h0);
		end
		// Stop, reserved modes and a foreign port all leave timer A still.
		foreach (stp[i]) begin
			port(stp[i][8:4], stp[i][3:0]);
			rd(1'b0, 2'h0, v0);
			tick(70);
			rd(1'b0, 2'h0, v);
			cmp(v, v0);
		end
		// Each rate runs timer B over an exact number of its pulse periods.
		for (int r = 0; r < 4; r++) begin
			port(5'h1d, 4'h0);
			load(1'b1, 2'h0, 4'h0);
			port(5'h1d, 4'(8 + r));
			tick(per[r] - 1);
			port(5'h1d, 4'h0);
			rd(1'b1, 2'h0, v);
			cmp(v, (r == 3) ? 4'h1 : 4'h4);
		end
		// Mid-run reset with timer A running, all gates open and two latches set.
		i_auto = 1'b0;
		port(5'h1c, 4'h8);
		setup(4'hf, 1'b1, 6'h3f);
		req(3'b011);
		reset_check();
		rd(1'b0, 2'h0, v0);
		tick(70);
		rd(1'b0, 2'h0, v);
		cmp(v, v0);
		finish_test();
	end
endmodule : dtiu_top_tb
